// file: design/pdmb_bridge.v
// Process data bridge between a Modbus request port and a fieldbus
// subnetwork data port, with endian swap and activity supervision.
// Assumes the request port is driven by same-clock protocol logic and the
// rotary switch pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none
`include "pdmb_regs.vh"

module pdmb_bridge
#(
  parameter P_TICK_10MS = `PDMB_TICKS_10MS,
  parameter P_FIFO_DEPTH = 16,
  parameter P_FIFO_AW    = 4
)
(
  input  wire        i_clk_sys,
  input  wire        i_sys_rst,
  input  wire        i_mb_req,
  input  wire [1:0]  i_mb_fn,
  input  wire [15:0] i_mb_addr,
  input  wire        i_mb_wr,
  input  wire [15:0] i_mb_wdata,
  output reg         o_mb_ack,
  output reg         o_mb_err,
  output reg  [15:0] o_mb_rdata,
  input  wire        i_conn_open,
  output reg         o_conn_close,
  input  wire        i_cfg_apply,
  input  wire [15:0] i_cfg_act_to,
  input  wire [15:0] i_cfg_conn_to,
  input  wire        i_cfg_same_size,
  input  wire [9:0]  i_cfg_mb_in_words,
  input  wire [9:0]  i_cfg_mb_out_words,
  input  wire [9:0]  i_cfg_sub_in_words,
  input  wire [9:0]  i_cfg_sub_out_words,
  input  wire [2:0]  i_cfg_swap_mb_out,
  input  wire [2:0]  i_cfg_swap_mb_in,
  input  wire [2:0]  i_cfg_swap_sub_out,
  input  wire [2:0]  i_cfg_swap_sub_in,
  input  wire [7:0]  i_cfg_det_modes,
  input  wire [35:0] i_cfg_det_groups,
  input  wire [6:0]  i_cfg_node_addr,
  input  wire [6:0]  i_rot_addr,
  input  wire        i_sub_cycle,
  output wire        o_sub_tx_valid,
  input  wire        i_sub_tx_ready,
  output wire [31:0] o_sub_tx_data,
  input  wire        i_sub_rx_valid,
  input  wire        i_sub_rx_first,
  input  wire [31:0] i_sub_rx_data,
  output reg         o_hl_offline,
  output wire        o_hl_idle,
  output reg  [6:0]  o_node_addr,
  output wire        o_stream_busy
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  reg [15:0] mem_out [0:`PDMB_MAX_WORDS-1];
  reg [15:0] mem_in  [0:`PDMB_MAX_WORDS-1];

  reg [15:0] act_to_reg;
  reg [15:0] conn_to_reg;
  reg [9:0]  mb_in_reg;
  reg [9:0]  mb_out_reg;
  reg [9:0]  sub_in_reg;
  reg [9:0]  sub_out_reg;
  reg [2:0]  sw_mb_out_reg;
  reg [2:0]  sw_mb_in_reg;
  reg [2:0]  sw_sub_out_reg;
  reg [2:0]  sw_sub_in_reg;
  reg [7:0]  det_modes_reg;
  reg [35:0] det_groups_reg;
  reg [6:0]  cfg_node_reg;
  reg [15:0] idle_reg;
  reg        same_size_reg;

  reg [31:0] tick_cnt_reg;
  reg        tick_10ms;
  reg [6:0]  step_cnt_reg;
  reg        tick_1s;
  reg [15:0] act_cnt_reg;
  reg [15:0] conn_cnt_reg;
  reg        conn_live_reg;

  reg [6:0]  rot_s1_reg;
  reg [6:0]  rot_s2_reg;
  reg [6:0]  rot_s3_reg;
  reg [6:0]  rot_stable_reg;

  reg        st_reg;
  reg [8:0]  tx_grp_reg;
  reg [8:0]  rx_grp_reg;

  wire       freeze;
  wire [9:0] out_words_sub;
  wire [9:0] in_words_sub;
  wire [8:0] tx_groups;
  wire [8:0] rx_grp;
  wire [9:0] tx_w0;
  wire [9:0] tx_w1;
  wire [9:0] rx_w0;
  wire [9:0] rx_w1;
  wire [31:0] tx_raw;
  wire [31:0] tx_swapped;
  wire [31:0] rx_swapped;
  wire       fifo_in_ready;
  wire       tx_push;
  wire [11:0] coil_word;
  wire [15:0] mirror_idx;

  // ****************************************************************
  // Swap helpers
  // ****************************************************************
  // Group bytes are A B C D from the lowest address; the first word of the
  // pair holds A in its high byte, so Modbus words read big-endian.
  function [31:0] swap32;
    input [31:0] d;
    input [1:0]  m;
    begin
      case (m)
        2'h1:    swap32 = {d[23:16], d[31:24], d[7:0], d[15:8]};
        2'h2:    swap32 = {d[15:0], d[31:16]};
        2'h3:    swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
        default: swap32 = d;
      endcase
    end
  endfunction

  // Picks the swap of a group: fixed modes apply to every group, detailed
  // mode walks the ordered object list; groups past the list pass plain.
  function [1:0] grp_mode;
    input [2:0]  sel;
    input [8:0]  g;
    input [7:0]  modes;
    input [35:0] counts;
    integer      k;
    reg   [9:0]  lo;
    reg   [9:0]  hi;
    reg          hit;
    begin
      lo  = 10'h000;
      hit = 1'b0;
      grp_mode = 2'h0;
      for (k = 0; k < `PDMB_DET_OBJECTS; k = k + 1)
      begin
        hi = lo + {1'b0, counts[k*9 +: 9]};
        if (!hit && ({1'b0, g} >= lo) && ({1'b0, g} < hi))
        begin
          grp_mode = modes[k*2 +: 2];
          hit = 1'b1;
        end
        lo = hi;
      end
      if (sel != `PDMB_SWAP_DETAIL)
        grp_mode = sel[1:0];
    end
  endfunction

  // ****************************************************************
  // Configuration apply
  // ****************************************************************
  // The whole active set is replaced at once on apply.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      act_to_reg     <= `PDMB_ACT_TO_RST;
      conn_to_reg    <= `PDMB_CONN_TO_RST;
      mb_in_reg      <= 10'h000;
      mb_out_reg     <= 10'h000;
      sub_in_reg     <= 10'h000;
      sub_out_reg    <= 10'h000;
      sw_mb_out_reg  <= `PDMB_SWAP_NONE;
      sw_mb_in_reg   <= `PDMB_SWAP_NONE;
      sw_sub_out_reg <= `PDMB_SWAP_NONE;
      sw_sub_in_reg  <= `PDMB_SWAP_NONE;
      det_modes_reg  <= 8'h00;
      det_groups_reg <= 36'h0;
      cfg_node_reg   <= `PDMB_NODE_RST;
    end
    else if (i_cfg_apply)
    begin
      act_to_reg     <= i_cfg_act_to;
      conn_to_reg    <= i_cfg_conn_to;
      mb_in_reg      <= (i_cfg_mb_in_words > `PDMB_MAX_WORDS) ?
                        `PDMB_MAX_WORDS : i_cfg_mb_in_words;
      mb_out_reg     <= (i_cfg_mb_out_words > `PDMB_MAX_WORDS) ?
                        `PDMB_MAX_WORDS : i_cfg_mb_out_words;
      sub_in_reg     <= (i_cfg_sub_in_words > `PDMB_MAX_WORDS) ?
                        `PDMB_MAX_WORDS : i_cfg_sub_in_words;
      sub_out_reg    <= (i_cfg_sub_out_words > `PDMB_MAX_WORDS) ?
                        `PDMB_MAX_WORDS : i_cfg_sub_out_words;
      sw_mb_out_reg  <= i_cfg_swap_mb_out;
      sw_mb_in_reg   <= i_cfg_swap_mb_in;
      sw_sub_out_reg <= i_cfg_swap_sub_out;
      sw_sub_in_reg  <= i_cfg_swap_sub_in;
      det_modes_reg  <= i_cfg_det_modes;
      det_groups_reg <= i_cfg_det_groups;
      cfg_node_reg   <= i_cfg_node_addr;
    end
  end

  // With common sizes the subnet uses the Modbus side sizes.
  assign out_words_sub = same_size_reg ? mb_out_reg : sub_out_reg;
  assign in_words_sub  = same_size_reg ? mb_in_reg  : sub_in_reg;

  // The size sharing choice is captured with the rest of the set.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      same_size_reg <= 1'b1;
    else if (i_cfg_apply)
      same_size_reg <= i_cfg_same_size;
  end

  // ****************************************************************
  // Time base: 10 ms step enable and one second enable
  // ****************************************************************
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      tick_cnt_reg <= 32'h0;
      tick_10ms    <= 1'b0;
      step_cnt_reg <= 7'h00;
      tick_1s      <= 1'b0;
    end
    else
    begin
      tick_10ms <= 1'b0;
      tick_1s   <= 1'b0;
      if (tick_cnt_reg == P_TICK_10MS - 1)
      begin
        tick_cnt_reg <= 32'h0;
        tick_10ms    <= 1'b1;
      end
      else
        tick_cnt_reg <= tick_cnt_reg + 32'h1;
      if (tick_10ms)
      begin
        if (step_cnt_reg == `PDMB_STEPS_PER_S - 1)
        begin
          step_cnt_reg <= 7'h00;
          tick_1s      <= 1'b1;
        end
        else
          step_cnt_reg <= step_cnt_reg + 7'h01;
      end
    end
  end

  // ****************************************************************
  // Activity and connection supervision
  // ****************************************************************
  // Every request is a message; a message in the same cycle as a timeout
  // wins, so the network stays online. A zero limit never times out.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst || i_cfg_apply)
    begin
      act_cnt_reg  <= 16'h0000;
      o_hl_offline <= 1'b0;
    end
    else if (i_mb_req)
    begin
      act_cnt_reg  <= 16'h0000;
      o_hl_offline <= 1'b0;
    end
    else if (act_to_reg == 16'h0000)
    begin
      act_cnt_reg  <= 16'h0000;
      o_hl_offline <= 1'b0;
    end
    else if (tick_10ms && !o_hl_offline)
    begin
      act_cnt_reg <= act_cnt_reg + 16'h0001;
      if (act_cnt_reg + 16'h0001 >= act_to_reg)
        o_hl_offline <= 1'b1;
    end
  end

  // An open connection counts idle seconds and is closed at the limit.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst || i_cfg_apply)
    begin
      conn_cnt_reg  <= 16'h0000;
      conn_live_reg <= 1'b0;
      o_conn_close  <= 1'b0;
    end
    else
    begin
      o_conn_close <= 1'b0;
      if (i_mb_req || i_conn_open)
      begin
        conn_cnt_reg  <= 16'h0000;
        conn_live_reg <= 1'b1;
      end
      else if (tick_1s && conn_live_reg && conn_to_reg != 16'h0000)
      begin
        conn_cnt_reg <= conn_cnt_reg + 16'h0001;
        if (conn_cnt_reg + 16'h0001 >= conn_to_reg)
        begin
          o_conn_close  <= 1'b1;
          conn_live_reg <= 1'b0;
        end
      end
    end
  end

  // Outbound data is frozen while offline or idle.
  assign freeze    = o_hl_offline | o_hl_idle;
  assign o_hl_idle = (idle_reg != 16'h0000);

  // ****************************************************************
  // Modbus request port
  // ****************************************************************
  assign coil_word  = i_mb_addr[15:`PDMB_COIL_SHIFT];
  assign mirror_idx = i_mb_addr - `PDMB_IN_MIRROR_BASE;

  // One request is answered on the next edge with ack, err and data.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      o_mb_ack   <= 1'b0;
      o_mb_err   <= 1'b0;
      o_mb_rdata <= 16'h0000;
      idle_reg   <= 16'h0000;
    end
    else
    begin
      o_mb_ack <= i_mb_req;
      o_mb_err <= 1'b0;
      if (i_cfg_apply)
        idle_reg <= 16'h0000;
      if (i_mb_req)
      begin
        o_mb_rdata <= 16'h0000;
        case (i_mb_fn)
          `PDMB_FN_COIL:
            if (coil_word < {2'b00, mb_out_reg})
            begin
              o_mb_rdata <= {15'h0000,
                             mem_out[coil_word[9:0]][i_mb_addr[3:0]]};
              if (i_mb_wr && !freeze)
                mem_out[coil_word[9:0]][i_mb_addr[3:0]] <= i_mb_wdata[0];
            end
            else
              o_mb_err <= 1'b1;
          `PDMB_FN_DISC:
            if (!i_mb_wr && coil_word < {2'b00, mb_in_reg})
              o_mb_rdata <= {15'h0000,
                             mem_in[coil_word[9:0]][i_mb_addr[3:0]]};
            else
              o_mb_err <= 1'b1;
          `PDMB_FN_IREG:
            if (!i_mb_wr && i_mb_addr < {6'h00, mb_in_reg})
              o_mb_rdata <= mem_in[i_mb_addr[9:0]];
            else
              o_mb_err <= 1'b1;
          default:
            if (i_mb_addr <= `PDMB_OUT_LAST &&
                i_mb_addr < {6'h00, mb_out_reg})
            begin
              o_mb_rdata <= mem_out[i_mb_addr[9:0]];
              if (i_mb_wr && !freeze)
                mem_out[i_mb_addr[9:0]] <= i_mb_wdata;
            end
            else if (i_mb_addr >= `PDMB_IN_MIRROR_BASE &&
                     i_mb_addr <= `PDMB_IN_MIRROR_LAST &&
                     mirror_idx < {6'h00, mb_in_reg} && !i_mb_wr)
              o_mb_rdata <= mem_in[mirror_idx[9:0]];
            else if (i_mb_addr == `PDMB_IDLE_REG)
            begin
              o_mb_rdata <= idle_reg;
              if (i_mb_wr)
                idle_reg <= i_mb_wdata;
            end
            else
              o_mb_err <= 1'b1;
        endcase
      end
    end
  end

  // ****************************************************************
  // Outbound stream towards the subnetwork
  // ****************************************************************
  assign tx_groups  = out_words_sub[9:1] + {8'h00, out_words_sub[0]};
  assign tx_w0      = {tx_grp_reg, 1'b0};
  assign tx_w1      = {tx_grp_reg, 1'b1};
  assign tx_raw     = {mem_out[tx_w0],
                       (tx_w1 < out_words_sub) ? mem_out[tx_w1] : 16'h0000};
  // Modbus side swap first, then the subnet side swap.
  assign tx_swapped = swap32(swap32(tx_raw,
                        grp_mode(sw_mb_out_reg, tx_grp_reg,
                                 det_modes_reg, det_groups_reg)),
                        grp_mode(sw_sub_out_reg, tx_grp_reg,
                                 det_modes_reg, det_groups_reg));
  assign tx_push       = (st_reg == ST_RUN);
  assign o_stream_busy = (st_reg == ST_RUN);

  // Each subnet cycle request taken in idle sends the whole output image, one group per
  // accepted FIFO slot; a full FIFO stalls the walk.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst || i_cfg_apply)
    begin
      st_reg     <= ST_IDLE;
      tx_grp_reg <= 9'h000;
    end
    else
    begin
      case (st_reg)
        ST_IDLE:
          if (i_sub_cycle && tx_groups != 9'h000)
          begin
            st_reg     <= ST_RUN;
            tx_grp_reg <= 9'h000;
          end
        ST_RUN:
          if (fifo_in_ready)
          begin
            if (tx_grp_reg == tx_groups - 9'h001)
              st_reg <= ST_IDLE;
            else
              tx_grp_reg <= tx_grp_reg + 9'h001;
          end
        default:
          st_reg <= ST_IDLE;
      endcase
    end
  end

  pdmb_fifo
  #(
    .P_WIDTH (32),
    .P_DEPTH (P_FIFO_DEPTH),
    .P_AW    (P_FIFO_AW)
  )
  u_tx_fifo
  (
    .i_clk_sys   (i_clk_sys),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (tx_push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (tx_swapped),
    .o_out_valid (o_sub_tx_valid),
    .i_out_ready (i_sub_tx_ready),
    .o_out_data  (o_sub_tx_data)
  );

  // ****************************************************************
  // Inbound groups from the subnetwork
  // ****************************************************************
  assign rx_grp     = i_sub_rx_first ? 9'h000 : rx_grp_reg;
  assign rx_w0      = {rx_grp, 1'b0};
  assign rx_w1      = {rx_grp, 1'b1};
  assign rx_swapped = swap32(swap32(i_sub_rx_data,
                        grp_mode(sw_sub_in_reg, rx_grp,
                                 det_modes_reg, det_groups_reg)),
                        grp_mode(sw_mb_in_reg, rx_grp,
                                 det_modes_reg, det_groups_reg));

  // Each received group lands as two words; words past the size are dropped.
  always @(posedge i_clk_sys)
  begin
    if (i_sub_rx_valid)
    begin
      if (rx_w0 < in_words_sub)
        mem_in[rx_w0] <= rx_swapped[31:16];
      if (rx_w1 < in_words_sub)
        mem_in[rx_w1] <= rx_swapped[15:0];
    end
  end

  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst || i_cfg_apply)
      rx_grp_reg <= 9'h000;
    else if (i_sub_rx_valid)
      rx_grp_reg <= rx_grp + 9'h001;
  end

  // ****************************************************************
  // Node address from rotary switches
  // ****************************************************************
  // Three-stage synchroniser; a value is taken once stages two and three
  // agree. Switches at zero select the configured address.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      rot_s1_reg     <= 7'h00;
      rot_s2_reg     <= 7'h00;
      rot_s3_reg     <= 7'h00;
      rot_stable_reg <= 7'h00;
      o_node_addr    <= `PDMB_NODE_RST;
    end
    else
    begin
      rot_s1_reg <= i_rot_addr;
      rot_s2_reg <= rot_s1_reg;
      rot_s3_reg <= rot_s2_reg;
      if (rot_s2_reg == rot_s3_reg)
        rot_stable_reg <= rot_s3_reg;
      o_node_addr <= (rot_stable_reg == 7'h00) ? cfg_node_reg :
                     rot_stable_reg;
    end
  end

endmodule // pdmb_bridge

`default_nettype wire

// file: design/pdmb_fifo.v
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module pdmb_fifo
#(
  parameter P_WIDTH = 32,
  parameter P_DEPTH = 16,
  parameter P_AW    = 4
)
(
  input  wire               i_clk_sys,
  input  wire               i_sys_rst,
  input  wire               i_in_valid,
  output wire               o_in_ready,
  input  wire [P_WIDTH-1:0] i_in_data,
  output wire               o_out_valid,
  input  wire               i_out_ready,
  output wire [P_WIDTH-1:0] o_out_data
);

  reg [P_WIDTH-1:0] mem [0:P_DEPTH-1];
  reg [P_AW-1:0]    wr_ptr_reg;
  reg [P_AW-1:0]    rd_ptr_reg;
  reg [P_AW:0]      count_reg;
  wire              push;
  wire              pop;

  // Full and empty come straight from the fill count.
  assign o_in_ready  = (count_reg != P_DEPTH[P_AW:0]);
  assign o_out_valid = (count_reg != {(P_AW+1){1'b0}});
  assign o_out_data  = mem[rd_ptr_reg];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // Storage is written without reset, it holds data only.
  always @(posedge i_clk_sys)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  // Pointers wrap at the depth and the count tracks both sides.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      wr_ptr_reg <= {P_AW{1'b0}};
      rd_ptr_reg <= {P_AW{1'b0}};
      count_reg  <= {(P_AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == P_DEPTH[P_AW-1:0] - 1'b1) ?
                      {P_AW{1'b0}} : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == P_DEPTH[P_AW-1:0] - 1'b1) ?
                      {P_AW{1'b0}} : rd_ptr_reg + 1'b1;
      if (push & ~pop)
        count_reg <= count_reg + 1'b1;
      else if (pop & ~push)
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule // pdmb_fifo

`default_nettype wire

// file: design/pdmb_regs.vh
// Constants for the process data mapping bridge: register numbers,
// request codes, swap codes, reset values and timing counts.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef PDMB_REGS_VH
`define PDMB_REGS_VH

// ****************************************************************
// Modbus object kinds on the request port
// ****************************************************************
`define PDMB_FN_COIL        2'h0
`define PDMB_FN_DISC        2'h1
`define PDMB_FN_IREG        2'h2
`define PDMB_FN_HREG        2'h3

// ****************************************************************
// Register numbers
// ****************************************************************
`define PDMB_OUT_BASE       16'h0000
`define PDMB_OUT_LAST       16'h02ED
`define PDMB_IN_BASE        16'h0000
`define PDMB_IN_MIRROR_BASE 16'h0800
`define PDMB_IN_MIRROR_LAST 16'h0AED
`define PDMB_IDLE_REG       16'h1004
`define PDMB_MAX_WORDS      10'h2EE
`define PDMB_COIL_SHIFT     4

// ****************************************************************
// Swap codes
// ****************************************************************
`define PDMB_SWAP_NONE      3'h0
`define PDMB_SWAP_BYTE      3'h1
`define PDMB_SWAP_WORD      3'h2
`define PDMB_SWAP_BOTH      3'h3
`define PDMB_SWAP_DETAIL    3'h4
`define PDMB_DET_OBJECTS    4

// ****************************************************************
// Reset values of the active configuration
// ****************************************************************
`define PDMB_ACT_TO_RST     16'h0000
`define PDMB_CONN_TO_RST    16'h003C
`define PDMB_NODE_RST       7'h7E

// ****************************************************************
// Timing
// ****************************************************************
`define PDMB_CLK_PERIOD_NS  20
`define PDMB_ACT_STEP_NS    10000000
`define PDMB_SECOND_NS      1000000000
`define PDMB_TICKS_10MS     (`PDMB_ACT_STEP_NS / `PDMB_CLK_PERIOD_NS)
`define PDMB_STEPS_PER_S    (`PDMB_SECOND_NS / `PDMB_ACT_STEP_NS)

`endif

// file: test/pdmb_bridge_tb.sv
// Self-checking bench for the bridge with a subnetwork model.
// Assumes a shortened 10 ms tick of ten clocks.
`timescale 1ns/100ps
`default_nettype none
module pdmb_bridge_tb;
  logic i_clk_sys = 0, i_sys_rst = 1, i_mb_req = 0, i_mb_wr = 0, snd = 0;
  logic i_conn_open = 0, i_cfg_apply = 0, i_cfg_same_size = 1, i_sub_cycle = 0;
  logic [1:0] i_mb_fn = 2'h0;
  logic [15:0] i_mb_addr = 16'h0, i_mb_wdata = 16'h0, w0, w1;
  logic [15:0] i_cfg_act_to = 16'h1, i_cfg_conn_to = 16'h1;
  logic [9:0] i_cfg_mb_in_words = 10'h4, i_cfg_mb_out_words = 10'h2;
  logic [9:0] i_cfg_sub_in_words = 10'h4, i_cfg_sub_out_words = 10'h2;
  logic [2:0] i_cfg_swap_mb_out = 3'h1, i_cfg_swap_mb_in = 3'h0;
  logic [2:0] i_cfg_swap_sub_out = 3'h4, i_cfg_swap_sub_in = 3'h2;
  logic [7:0] i_cfg_det_modes = 8'h03;
  logic [35:0] i_cfg_det_groups = 36'h1;
  logic [6:0] i_cfg_node_addr = 7'h12, i_rot_addr = 7'h0;
  logic [31:0] rnd = 32'h7706;
  logic [17:0] v;
  logic hs = 0;
  logic [31:0] td = 32'h0;
  wire o_mb_ack, o_mb_err, o_conn_close, o_sub_tx_valid, o_hl_offline;
  wire o_hl_idle, o_stream_busy, i_sub_tx_ready, i_sub_rx_valid, i_sub_rx_first;
  wire [15:0] o_mb_rdata;
  wire [31:0] o_sub_tx_data, i_sub_rx_data;
  wire [6:0] o_node_addr;
  logic [17:0] q[$];
  logic [31:0] qt[$];
  int fail_count = 0, n_tests = 0, i;
  pdmb_bridge #(.P_TICK_10MS(10)) pdmb_bridge_inst (.*);
  pdmb_sub_model pdmb_sub_model_inst (.i_clk_sys(i_clk_sys), .i_send(snd),
    .i_grp(32'hAABBCCDD), .o_tx_ready(i_sub_tx_ready),
    .o_rx_valid(i_sub_rx_valid), .o_rx_first(i_sub_rx_first),
    .o_rx_data(i_sub_rx_data));
  initial forever #10 i_clk_sys = ~i_clk_sys;
  function [31:0] lf(input [31:0] s);
    lf = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cmp(input string s, input [31:0] e, input [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task report_and_stop;
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task tmo(input bit ok);
    cmp("wait", 1, ok);
    if (!ok) report_and_stop();
  endtask
  // One register cycle; c says whether read data is compared.
  task mb(input [1:0] f, input [15:0] a, input w, input [15:0] d, input c,
          input e, input [15:0] x);
    @(negedge i_clk_sys);
    {i_mb_req, i_mb_fn, i_mb_addr, i_mb_wr, i_mb_wdata} = {1'b1, f, a, w, d};
    q.push_back({c, e, x});
    @(negedge i_clk_sys);
    i_mb_req = 0;
  endtask
  // Answers are taken from the note queues as they appear.
  always @(negedge i_clk_sys)
  begin
    if (o_mb_ack === 1'b1)
    begin
      v = q.pop_front();
      cmp("err", v[16], o_mb_err);
      if (v[17]) cmp("rdata", v[15:0], o_mb_rdata);
    end
    if (hs === 1'b1)
      cmp("tx", qt.pop_front(), td);
  end
  // Output handshakes are caught at the rising edge that takes them.
  always @(posedge i_clk_sys)
  begin
    hs <= o_sub_tx_valid && i_sub_tx_ready;
    td <= o_sub_tx_data;
  end
  initial
  begin
    repeat (6) @(negedge i_clk_sys);
    i_sys_rst = 0;
    repeat (30) @(negedge i_clk_sys);
    cmp("offline", 0, o_hl_offline);
    i_cfg_apply = 1;
    @(negedge i_clk_sys);
    {i_cfg_apply, i_conn_open} = 2'b01;
    @(negedge i_clk_sys);
    i_conn_open = 0;
    rnd = lf(rnd);
    {w0, w1} = rnd;
    cmp("node", 7'h12, o_node_addr);
    mb(2'h3, 16'h0, 1, w0, 0, 0, 0);
    mb(2'h3, 16'h1, 1, w1, 0, 0, 0);
    mb(2'h0, 16'h10, 0, 0, 1, 0, {15'h0, w1[0]});
    mb(2'h1, 16'h0, 1, 0, 0, 1, 0);
    snd = 1;
    @(negedge i_clk_sys);
    snd = 0;
    mb(2'h2, 16'h0, 0, 0, 1, 0, 16'hCCDD);
    mb(2'h3, 16'h801, 0, 0, 1, 0, 16'hAABB);
    // Byte swap, then a detailed full reverse, exchanges the two words.
    qt.push_back({w1, w0});
    i_sub_cycle = 1;
    @(negedge i_clk_sys);
    i_sub_cycle = 0;
    cmp("busy", 1, o_stream_busy);
    for (i = 0; i < 40 && qt.size() > 0; i++) @(negedge i_clk_sys);
    tmo(i < 40);
    for (i = 0; i < 40 && o_hl_offline !== 1'b1; i++) @(negedge i_clk_sys);
    tmo(i < 40);
    mb(2'h3, 16'h0, 1, ~w0, 0, 0, 0);
    mb(2'h3, 16'h0, 0, 0, 1, 0, w0);
    mb(2'h3, 16'h1004, 1, 16'h1, 0, 0, 0);
    cmp("idle", 1, o_hl_idle);
    for (i = 0; i < 3000 && o_conn_close !== 1'b1; i++) @(negedge i_clk_sys);
    tmo(i < 3000);
    i_rot_addr = 7'h05;
    repeat (10) @(negedge i_clk_sys);
    cmp("node", 7'h05, o_node_addr);
    cmp("queue", 0, q.size() + qt.size());
    report_and_stop();
  end
endmodule // pdmb_bridge_tb
bind pdmb_bridge pdmb_checker pdmb_checker_inst (.*);
`default_nettype wire

// file: test/pdmb_checker.sv
// Port checker for the process data bridge.
// Assumes a bind onto pdmb_bridge with one clock and high reset.
`timescale 1ns/100ps
`default_nettype none
module pdmb_checker (
  input wire        i_clk_sys, i_sys_rst, i_mb_req, i_mb_wr,
  input wire        o_mb_ack, o_mb_err, o_hl_offline, o_hl_idle,
  input wire        o_conn_close, o_sub_tx_valid, i_sub_tx_ready,
  input wire [1:0]  i_mb_fn,
  input wire [15:0] i_mb_addr, i_mb_wdata,
  input wire [31:0] o_sub_tx_data,
  input wire [6:0]  i_rot_addr, o_node_addr
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // A stalled output group, and an idle register write.
  sequence s_stall; o_sub_tx_valid && !i_sub_tx_ready; endsequence
  sequence s_idle_wr;
    i_mb_req && i_mb_wr && i_mb_fn == 2'h3 && i_mb_addr == 16'h1004;
  endsequence
  property p_ack; i_mb_req |=> o_mb_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_noack; !i_mb_req |=> !o_mb_ack; endproperty
  a_noack: assert property (p_noack) else $error("ack unasked");
  property p_err; o_mb_err |-> o_mb_ack; endproperty
  a_err: assert property (p_err) else $error("err alone");
  property p_hold; s_stall |=> o_sub_tx_valid && $stable(o_sub_tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("tx moved");
  property p_online; i_mb_req |=> !o_hl_offline; endproperty
  a_online: assert property (p_online) else $error("still off");
  property p_idle; s_idle_wr ##0 (i_mb_wdata != 16'h0) |=> o_hl_idle;
  endproperty
  a_idle: assert property (p_idle) else $error("no idle");
  property p_close; o_conn_close |=> !o_conn_close; endproperty
  a_close: assert property (p_close) else $error("close stuck");
  property p_node;
    (i_rot_addr != 7'h0 && $stable(i_rot_addr)) [*6] |-> o_node_addr == i_rot_addr;
  endproperty
  a_node: assert property (p_node) else $error("node wrong");
endmodule // pdmb_checker
`default_nettype wire

// file: test/pdmb_sub_model.sv
// Subnetwork side model: stalls the output stream, sends input groups.
// Assumes the bench asks for each input group on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module pdmb_sub_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_send,
  input  wire logic [31:0] i_grp,
  output logic             o_tx_ready = 1'b0,
  output logic             o_rx_valid = 1'b0,
  output logic             o_rx_first = 1'b0,
  output logic [31:0]      o_rx_data = 32'h0
);
  // Ready toggles to stall; idle data inverts so it never looks valid.
  always @(negedge i_clk_sys)
  begin
    o_tx_ready <= ~o_tx_ready;
    o_rx_valid <= i_send;
    o_rx_first <= i_send;
    o_rx_data  <= i_send ? i_grp : ~o_rx_data;
  end
endmodule // pdmb_sub_model
`default_nettype wire
